// ==== hw/rxfcb_pkg.sv ====
// rxfcb_pkg: shared constants of the receiver configuration bank
// assumes: byte addresses are four times the printed register index
package rxfcb_pkg;
    // printed register indices; byte address is four times the index
    localparam logic [7:0] IDX_CHFILT = 8'h0B;
    localparam logic [7:0] IDX_DEMOD = 8'h0C;
    localparam logic [7:0] IDX_GAIN1 = 8'h0D;
    localparam logic [7:0] IDX_GAIN2 = 8'h0E;
    // own control register: bit 0 reload pulse, bit 1 manual choice
    localparam logic [7:0] IDX_CTRL = 8'h10;
    // own status register: live squelch, loaded later-stage gain
    localparam logic [7:0] IDX_STAT = 8'h11;
    localparam logic [7:0] RST_CHFILT = 8'h00;
    localparam logic [7:0] RST_DEMOD = 8'h2C;
    localparam logic [7:0] RST_GAIN1 = 8'hD8;
    localparam logic [7:0] RST_GAIN2 = 8'h00;
    localparam int BIT_CHSEL = 7;
    localparam int BIT_DEMOD = 7;
    localparam int BIT_AMDSEL = 6;
    localparam int BIT_SQDYN = 5;
    localparam int BIT_SQRATIO = 4;
    localparam int BIT_AGCEN = 3;
    localparam int BIT_AGCSPAN = 2;
    localparam int BIT_AGCALG = 1;
    localparam int BIT_AGCRATIO = 0;
    localparam int BIT_LFEN = 1;
    localparam int BIT_LFSPLIT = 0;
    localparam logic [3:0] GAIN2_MAX = 4'h0A;
    localparam logic [3:0] GAIN2_WINMAX = 4'h4;
    // squelch on-delay after end of transmit
    localparam real SQ_DELAY_NS = 18880.0;
    localparam real CLK_PERIOD_NS = 50.0;
    localparam int SQ_DELAY_CYC = int'($ceil(SQ_DELAY_NS / CLK_PERIOD_NS));
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : rxfcb_pkg

// ==== hw/rxfcb_gain_if.sv ====
// rxfcb_gain_if: carries one channel's later-stage gain decode
// assumes: one producer, the top as consumer
`timescale 1ns/1ns
interface rxfcb_gain_if;
    logic [2:0] window;
    logic [2:0] stage;
    modport prod (output window, output stage);
    modport cons (input window, input stage);
endinterface : rxfcb_gain_if

// ==== hw/rxfcb_gain_decode.sv ====
// rxfcb_gain_decode: splits a later-stage gain code into digitizer window
// steps and amplifier steps; assumes codes above 0xA never arrive
`timescale 1ns/1ns
module rxfcb_gain_decode (
    input wire logic [3:0] code,
    rxfcb_gain_if.prod dec
);
    always_comb begin
        // codes 1..4 widen only the window
        if (code <= rxfcb_pkg::GAIN2_WINMAX) begin
            dec.window = code[2:0];
            dec.stage = 3'h0;
        end else begin
            dec.window = rxfcb_pkg::GAIN2_WINMAX[2:0];
            dec.stage = 3'(code - rxfcb_pkg::GAIN2_WINMAX);
        end
    end
endmodule : rxfcb_gain_decode

// ==== hw/rxfcb_squelch_timer.sv ====
// rxfcb_squelch_timer: automatic squelch after end of transmit
// assumes: txEnd is a one-cycle pulse, maskDone a level from the timer
`timescale 1ns/1ns
module rxfcb_squelch_timer #(
    parameter int DELAY = rxfcb_pkg::SQ_DELAY_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic txEnd,
    input wire logic maskDone,
    output logic squelchOn
);
    typedef enum logic [1:0] {IDLE, WAIT, ON} rxfcb_sq_type;
    rxfcb_sq_type state;
    logic [9:0] count;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= IDLE;
            count <= 10'h000;
        end else if (!enable) begin
            state <= IDLE;
            count <= 10'h000;
        end else begin
            unique case (state)
                IDLE: if (txEnd) begin
                    state <= WAIT;
                    count <= 10'h001;
                end
                WAIT: if (count == 10'(DELAY)) begin
                    state <= ON;
                end else begin
                    count <= count + 10'h001;
                end
                ON: if (maskDone) begin
                    state <= IDLE;
                end
            endcase
        end
    end
    assign squelchOn = (state == ON);
endmodule : rxfcb_squelch_timer

// ==== hw/rxfcb_top.sv ====
// rxfcb_top: receiver configuration bank behind an AXI4-Lite slave
// assumes: analogue controls sampled on ref_clk; one access at a time
`timescale 1ns/1ns
module rxfcb_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic amEnabled,
    input wire logic pmEnabled,
    input wire logic txEnd,
    input wire logic maskDone,
    input wire logic [4:0] subcarrierStartTime,
    output logic amChannelOn,
    output logic pmChannelOn,
    output logic framePm,
    output logic [2:0] lowpassControl,
    output logic [3:0] zeroSetting,
    output logic iqDemod,
    output logic mixerDetector,
    output logic squelchActive,
    output logic squelchRatioHigh,
    output logic gainLoopOn,
    output logic gainLoopWhole,
    output logic gainLoopReset,
    output logic gainLoopRatio,
    output logic [2:0] amFirstStageGain,
    output logic [2:0] pmFirstStageGain,
    output logic lowFreqInputEnable,
    output logic lowFreqInputSplit,
    output logic [2:0] amWindowSteps,
    output logic [2:0] amStageSteps,
    output logic [2:0] pmWindowSteps,
    output logic [2:0] pmStageSteps,
    output logic [4:0] scStartQuarters
);
    logic [7:0] rxChannelFilterCfg;
    logic [7:0] rxDemodSquelchGainloopCfg;
    logic [7:0] rxFirstStageGainCfg;
    logic [7:0] rxLaterStageGainCfg;
    logic [7:0] loadedGain;
    logic manualChoice;
    logic haveAw;
    logic haveW;
    logic [7:0] awIdx;
    logic [7:0] wByte;
    logic wLane;
    logic squelchOn;
    logic [7:0] arIdx;
    logic doWrite;
    rxfcb_gain_if amDec ();
    rxfcb_gain_if pmDec ();

    ////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    assign doWrite = haveAw && haveW && !s_axi_bvalid;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            haveAw <= 1'b0;
            haveW <= 1'b0;
            awIdx <= 8'h00;
            wByte <= 8'h00;
            wLane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rxfcb_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                haveAw <= 1'b1;
                awIdx <= {2'b00, s_axi_awaddr[7:2]};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                haveW <= 1'b1;
                wByte <= s_axi_wdata[7:0];
                wLane <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                haveAw <= 1'b0;
                haveW <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (awIdx)
                    rxfcb_pkg::IDX_CHFILT, rxfcb_pkg::IDX_DEMOD,
                    rxfcb_pkg::IDX_GAIN1, rxfcb_pkg::IDX_GAIN2,
                    rxfcb_pkg::IDX_CTRL, rxfcb_pkg::IDX_STAT:
                        s_axi_bresp <= rxfcb_pkg::RESP_OKAY;
                    default: s_axi_bresp <= rxfcb_pkg::RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register storage; only byte lane 0 carries data
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rxChannelFilterCfg <= rxfcb_pkg::RST_CHFILT;
            rxDemodSquelchGainloopCfg <= rxfcb_pkg::RST_DEMOD;
            rxFirstStageGainCfg <= rxfcb_pkg::RST_GAIN1;
            rxLaterStageGainCfg <= rxfcb_pkg::RST_GAIN2;
            manualChoice <= 1'b0;
        end else if (doWrite && wLane) begin
            unique case (awIdx)
                rxfcb_pkg::IDX_CHFILT: rxChannelFilterCfg <= wByte;
                rxfcb_pkg::IDX_DEMOD: rxDemodSquelchGainloopCfg <= wByte;
                rxfcb_pkg::IDX_GAIN1: rxFirstStageGainCfg <= wByte;
                rxfcb_pkg::IDX_GAIN2: rxLaterStageGainCfg <= wByte;
                rxfcb_pkg::IDX_CTRL: manualChoice <= wByte[1];
                default: ;
            endcase
        end
    end

    // reload command: bit 0 of the control word, self-clearing
    // the loaded copy lags the register so stray writes stay harmless
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            loadedGain <= rxfcb_pkg::RST_GAIN2;
        end else if (doWrite && wLane && awIdx == rxfcb_pkg::IDX_CTRL
                     && wByte[0]) begin
            loadedGain <= rxLaterStageGainCfg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel: one cycle from address to data
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rxfcb_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rxfcb_pkg::RESP_OKAY;
            unique case (arIdx)
                rxfcb_pkg::IDX_CHFILT:
                    s_axi_rdata <= {24'h00_0000, rxChannelFilterCfg};
                rxfcb_pkg::IDX_DEMOD:
                    s_axi_rdata <= {24'h00_0000, rxDemodSquelchGainloopCfg};
                rxfcb_pkg::IDX_GAIN1:
                    s_axi_rdata <= {24'h00_0000, rxFirstStageGainCfg};
                rxfcb_pkg::IDX_GAIN2:
                    s_axi_rdata <= {24'h00_0000, rxLaterStageGainCfg};
                rxfcb_pkg::IDX_CTRL:
                    s_axi_rdata <= {30'h0000_0000, manualChoice, 1'b0};
                rxfcb_pkg::IDX_STAT:
                    s_axi_rdata <= {23'h00_0000, squelchOn, loadedGain};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= rxfcb_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    assign arIdx = {2'b00, s_axi_araddr[7:2]};

    ////////////////////////////////////////////////////////////////////
    // decode of the later-stage gain uses the reloaded copy
    rxfcb_gain_decode amGain (.code(loadedGain[7:4]), .dec(amDec.prod));
    rxfcb_gain_decode pmGain (.code(loadedGain[3:0]), .dec(pmDec.prod));

    rxfcb_squelch_timer squelch (
        .ref_clk(ref_clk),
        .reset(reset),
        .enable(rxDemodSquelchGainloopCfg[rxfcb_pkg::BIT_SQDYN]),
        .txEnd(txEnd),
        .maskDone(maskDone),
        .squelchOn(squelchOn)
    );

    ////////////////////////////////////////////////////////////////////
    // analogue controls, all registered
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            amChannelOn <= 1'b0;
            pmChannelOn <= 1'b0;
            framePm <= 1'b0;
            lowpassControl <= 3'h0;
            zeroSetting <= 4'h0;
            iqDemod <= 1'b0;
            mixerDetector <= 1'b0;
            squelchActive <= 1'b0;
            squelchRatioHigh <= 1'b0;
            gainLoopOn <= 1'b0;
            gainLoopWhole <= 1'b0;
            gainLoopReset <= 1'b0;
            gainLoopRatio <= 1'b0;
            amFirstStageGain <= 3'h0;
            pmFirstStageGain <= 3'h0;
            lowFreqInputEnable <= 1'b0;
            lowFreqInputSplit <= 1'b0;
            amWindowSteps <= 3'h0;
            amStageSteps <= 3'h0;
            pmWindowSteps <= 3'h0;
            pmStageSteps <= 3'h0;
            scStartQuarters <= 5'h00;
        end else begin
            // single channel: choice bit picks which one runs
            if (amEnabled ^ pmEnabled) begin
                amChannelOn <= !rxChannelFilterCfg[rxfcb_pkg::BIT_CHSEL];
                pmChannelOn <= rxChannelFilterCfg[rxfcb_pkg::BIT_CHSEL];
            end else begin
                amChannelOn <= amEnabled;
                pmChannelOn <= pmEnabled;
            end
            framePm <= (amEnabled && pmEnabled && manualChoice)
                ? rxChannelFilterCfg[rxfcb_pkg::BIT_CHSEL]
                : (pmEnabled && !amEnabled);
            lowpassControl <= rxChannelFilterCfg[6:4];
            zeroSetting <= rxChannelFilterCfg[3:0];
            // I/Q forces the mixer; peak detector is unusable there
            iqDemod <= rxDemodSquelchGainloopCfg[rxfcb_pkg::BIT_DEMOD];
            mixerDetector <= rxDemodSquelchGainloopCfg[rxfcb_pkg::BIT_AMDSEL]
                || rxDemodSquelchGainloopCfg[rxfcb_pkg::BIT_DEMOD];
            squelchActive <= squelchOn;
            squelchRatioHigh <=
                rxDemodSquelchGainloopCfg[rxfcb_pkg::BIT_SQRATIO];
            gainLoopOn <= rxDemodSquelchGainloopCfg[rxfcb_pkg::BIT_AGCEN];
            gainLoopWhole <=
                rxDemodSquelchGainloopCfg[rxfcb_pkg::BIT_AGCSPAN];
            gainLoopReset <=
                rxDemodSquelchGainloopCfg[rxfcb_pkg::BIT_AGCALG];
            gainLoopRatio <=
                rxDemodSquelchGainloopCfg[rxfcb_pkg::BIT_AGCRATIO];
            amFirstStageGain <= rxFirstStageGainCfg[7:5];
            pmFirstStageGain <= rxFirstStageGainCfg[4:2];
            lowFreqInputEnable <=
                rxFirstStageGainCfg[rxfcb_pkg::BIT_LFEN];
            lowFreqInputSplit <=
                rxFirstStageGainCfg[rxfcb_pkg::BIT_LFSPLIT];
            amWindowSteps <= amDec.window;
            amStageSteps <= amDec.stage;
            pmWindowSteps <= pmDec.window;
            pmStageSteps <= pmDec.stage;
            scStartQuarters <= subcarrierStartTime;
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_chsel;
        @(posedge ref_clk) disable iff (reset)
        (amEnabled && !pmEnabled) |=> (pmChannelOn == $past(
            rxChannelFilterCfg[rxfcb_pkg::BIT_CHSEL]));
    endproperty
    a_chsel: assert property (p_chsel) else $error("channel choice");
    property p_frame;
        @(posedge ref_clk) disable iff (reset)
        (amEnabled && pmEnabled && manualChoice) |=>
            (framePm == $past(rxChannelFilterCfg[7]));
    endproperty
    a_frame: assert property (p_frame) else $error("framing wrong");
    property p_lp;
        @(posedge ref_clk) disable iff (reset)
        1'b1 |=> lowpassControl == $past(rxChannelFilterCfg[6:4]);
    endproperty
    a_lp: assert property (p_lp) else $error("low-pass mismatch");
    property p_iq;
        @(posedge ref_clk) disable iff (reset) iqDemod |-> mixerDetector;
    endproperty
    a_iq: assert property (p_iq) else $error("iq without mixer");
    property p_sq_early;
        @(posedge ref_clk) disable iff (reset)
        (txEnd && !squelchOn) |=> !squelchOn [*8];
    endproperty
    a_sq_early: assert property (p_sq_early) else $error("sq early");
    property p_gain1;
        @(posedge ref_clk) disable iff (reset)
        1'b1 |=> amFirstStageGain == $past(rxFirstStageGainCfg[7:5]);
    endproperty
    a_gain1: assert property (p_gain1) else $error("first gain wrong");
    property p_window;
        @(posedge ref_clk) disable iff (reset)
        (loadedGain[7:4] <= 4'h4) |=> (amStageSteps == 3'h0);
    endproperty
    a_window: assert property (p_window) else $error("stage early");
    property p_stage;
        @(posedge ref_clk) disable iff (reset)
        (loadedGain[3:0] > 4'h4 && loadedGain[3:0] <= 4'hA) |=>
            (pmWindowSteps == 3'h4 && pmStageSteps != 3'h0);
    endproperty
    a_stage: assert property (p_stage) else $error("no stage step");
    property p_reload;
        @(posedge ref_clk) disable iff (reset)
        !(doWrite && awIdx == rxfcb_pkg::IDX_CTRL) |=> $stable(loadedGain);
    endproperty
    a_reload: assert property (p_reload) else $error("early copy");
endmodule : rxfcb_top

// ==== tb/rxfcb_top_test.sv ====
// rxfcb_top_test: self-checking bench for the receiver configuration bank
// assumes: package, gain interface and submodules are compiled before it
`timescale 1ns/1ns
module rxfcb_top_test;
    logic ref_clk, reset, awValid, wValid, bReady, arValid, rReady;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [7:0] awAddr, arAddr;
    logic [31:0] wData, rData;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp;
    logic amEnabled, pmEnabled, txEnd, maskDone, amChannelOn, pmChannelOn;
    logic framePm, iqDemod, mixerDetector, squelchActive, squelchRatioHigh;
    logic gainLoopOn, gainLoopWhole, gainLoopReset, gainLoopRatio;
    logic lowFreqInputEnable, lowFreqInputSplit;
    logic [2:0] lowpassControl, amFirstStageGain, pmFirstStageGain;
    logic [2:0] amWindowSteps, amStageSteps, pmWindowSteps, pmStageSteps;
    logic [3:0] zeroSetting;
    logic [4:0] scTime, scStartQuarters;
    int failures, num_checks, cycles;
    logic [1:0] resp;
    logic [31:0] rd;
    logic [7:0] v;
    int n;
    logic [7:0] demodCodes[5] = '{8'hC0, 8'h40, 8'h1F, 8'h15, 8'h0A};
    logic [7:0] gainCodes[3] = '{8'hE5, 8'h1A, 8'h00};

    rxfcb_top i_dut (.ref_clk, .reset, .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .amEnabled, .pmEnabled,
        .txEnd, .maskDone, .subcarrierStartTime(scTime), .amChannelOn,
        .pmChannelOn, .framePm, .lowpassControl, .zeroSetting, .iqDemod,
        .mixerDetector, .squelchActive, .squelchRatioHigh, .gainLoopOn,
        .gainLoopWhole, .gainLoopReset, .gainLoopRatio, .amFirstStageGain,
        .pmFirstStageGain, .lowFreqInputEnable, .lowFreqInputSplit,
        .amWindowSteps, .amStageSteps, .pmWindowSteps, .pmStageSteps,
        .scStartQuarters);

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // byte address is four times the register index
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] strb, output logic [1:0] r);
        awAddr <= {idx[5:0], 2'b00};
        wData <= {24'h00_0000, d};
        wStrb <= strb;
        awValid <= 1'b1;
        wValid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
        end while (!bValid);
        r = bResp;
    endtask : wr

    task automatic rdreg(input logic [7:0] idx, output logic [31:0] d,
                         output logic [1:0] r);
        arAddr <= {idx[5:0], 2'b00};
        arValid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arValid && arReady) arValid <= 1'b0;
        end while (!rValid);
        d = rData;
        r = rResp;
    endtask : rdreg

    // write a mapped register, expect OKAY, let outputs settle
    task automatic put(input logic [7:0] idx, input logic [7:0] d);
        wr(idx, d, 4'h1, resp);
        check(resp, rxfcb_pkg::RESP_OKAY);
        repeat (3) @(posedge ref_clk);
    endtask : put

    task automatic expect_reg(input logic [7:0] idx, input logic [7:0] d);
        rdreg(idx, rd, resp);
        check({rd, resp}, {24'h00_0000, d, rxfcb_pkg::RESP_OKAY});
    endtask : expect_reg

    task automatic pulse_tx;
        txEnd <= 1'b1;
        @(posedge ref_clk);
        txEnd <= 1'b0;
    endtask : pulse_tx

    // hang guard: whole run needs about a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        num_checks = 0;
        cycles = 0;
        reset = 1'b1;
        // response readies stay high so back-to-back calls never
        // lower and raise them in one time step
        {awValid, wValid, bReady, arValid, rReady} = 5'h05;
        awAddr = 8'h00;
        arAddr = 8'h00;
        wData = 32'h0000_0000;
        wStrb = 4'h0;
        {amEnabled, pmEnabled, txEnd, maskDone} = 4'b1000;
        scTime = 5'h13;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        expect_reg(rxfcb_pkg::IDX_CHFILT, 8'h00);
        expect_reg(rxfcb_pkg::IDX_DEMOD, 8'h2C);
        expect_reg(rxfcb_pkg::IDX_GAIN1, 8'hD8);
        expect_reg(rxfcb_pkg::IDX_GAIN2, 8'h00);
        check({gainLoopOn, gainLoopWhole, gainLoopReset, gainLoopRatio},
              4'hC);
        check({amFirstStageGain, pmFirstStageGain}, 6'h36);
        check(scStartQuarters, 5'h13);
        scTime <= 5'h1F;
        // only the AM enable is up: the choice bit names the live channel
        put(rxfcb_pkg::IDX_CHFILT, 8'hD5);
        check({amChannelOn, pmChannelOn}, 2'b01);
        check({lowpassControl, zeroSetting}, 7'h55);
        check(scStartQuarters, 5'h1F);
        expect_reg(rxfcb_pkg::IDX_CHFILT, 8'hD5);
        put(rxfcb_pkg::IDX_CHFILT, 8'h2A);
        check({amChannelOn, pmChannelOn}, 2'b10);
        check({lowpassControl, zeroSetting}, 7'h2A);
        // both enabled with manual choice: choice bit picks framing
        pmEnabled <= 1'b1;
        put(rxfcb_pkg::IDX_CTRL, 8'h02);
        check(framePm, 1'b0);
        put(rxfcb_pkg::IDX_CHFILT, 8'h80);
        check(framePm, 1'b1);
        // byte lane 0 off: write is dropped yet answered OKAY
        wr(rxfcb_pkg::IDX_CHFILT, 8'hFF, 4'hE, resp);
        check(resp, rxfcb_pkg::RESP_OKAY);
        expect_reg(rxfcb_pkg::IDX_CHFILT, 8'h80);
        // unmapped index: error response and zero data
        wr(8'h20, 8'h55, 4'h1, resp);
        check(resp, rxfcb_pkg::RESP_SLVERR);
        rdreg(8'h20, rd, resp);
        check({rd, resp}, {32'h0000_0000, rxfcb_pkg::RESP_SLVERR});
        // the host always pairs I/Q with the mixer detector
        foreach (demodCodes[i]) begin
            v = demodCodes[i];
            put(rxfcb_pkg::IDX_DEMOD, v);
            check({iqDemod, mixerDetector}, {v[7], v[6]});
            check({squelchRatioHigh, gainLoopOn, gainLoopWhole},
                  v[4:2]);
            check({gainLoopReset, gainLoopRatio}, v[1:0]);
            expect_reg(rxfcb_pkg::IDX_DEMOD, v);
        end
        foreach (gainCodes[i]) begin
            v = gainCodes[i];
            put(rxfcb_pkg::IDX_GAIN1, v);
            check({amFirstStageGain, pmFirstStageGain}, v[7:2]);
            check({lowFreqInputEnable, lowFreqInputSplit}, v[1:0]);
            expect_reg(rxfcb_pkg::IDX_GAIN1, v);
        end
        // later-stage gain stays unloaded until the reload command
        put(rxfcb_pkg::IDX_GAIN2, 8'h3A);
        rdreg(rxfcb_pkg::IDX_STAT, rd, resp);
        check(rd[7:0], 8'h00);
        put(rxfcb_pkg::IDX_CTRL, 8'h03);
        rdreg(rxfcb_pkg::IDX_STAT, rd, resp);
        check(rd[7:0], 8'h3A);
        for (int c = 0; c <= 10; c++) begin
            v = {c[3:0], 4'(10 - c)};
            put(rxfcb_pkg::IDX_GAIN2, v);
            put(rxfcb_pkg::IDX_CTRL, 8'h03);
            check({amWindowSteps, amStageSteps},
                  {(c > 4) ? 3'h4 : c[2:0],
                   (c > 4) ? 3'(c - 4) : 3'h0});
            check({pmWindowSteps, pmStageSteps}, {(c < 6) ? 3'd4 :
                  3'(10 - c), (c < 6) ? 3'(6 - c) : 3'd0});
        end
        // automatic squelch off: end of transmit leaves squelch down
        pulse_tx();
        repeat (400) @(posedge ref_clk);
        check(squelchActive, 1'b0);
        put(rxfcb_pkg::IDX_DEMOD, 8'h2C);
        pulse_tx();
        n = 0;
        while (squelchActive !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        // 18.88 us is 378 cycles; allow the output register stages
        check(n >= 376 && n <= 381, 1'b1);
        maskDone <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(squelchActive, 1'b0);
        maskDone <= 1'b0;
        results();
    end

endmodule : rxfcb_top_test
